//--- dmacs_pkg.sv
/*
  constants, enumerations and field positions for the dma channel select and
  command block. assumes nothing beyond a systemverilog compiler.
*/
package dmacs_pkg;

  // ****************************************
  // coprocessor encodings
  // ****************************************
  localparam logic [2:0] DMACS_OPC1_DMA = 3'h0; // first opcode of all dma registers
  localparam logic [3:0] DMACS_CRN_DMA = 4'hB; // primary register c11
  localparam logic [3:0] DMACS_CRM_IDSTAT = 4'h0; // id and status, handled elsewhere
  localparam logic [3:0] DMACS_CRM_UACC = 4'h1; // user access register
  localparam logic [3:0] DMACS_CRM_CHSEL = 4'h2; // channel selector
  localparam logic [3:0] DMACS_CRM_CMD = 4'h3; // command registers
  localparam logic [3:0] DMACS_CRM_BANK_MIN = 4'h4; // first banked secondary register
  localparam logic [2:0] DMACS_OPC2_ZERO = 3'h0; // second opcode of uacc and chsel
  localparam logic [2:0] DMACS_OPC2_HALT = 3'h0; // halt command
  localparam logic [2:0] DMACS_OPC2_LAUNCH = 3'h1; // launch command
  localparam logic [2:0] DMACS_OPC2_CLEAR = 3'h2; // clear command

  // ****************************************
  // register fields and reset values
  // ****************************************
  localparam int DMACS_NUM_CH = 2; // implemented channels
  localparam int DMACS_CHSEL_BIT = 0; // channel_select_bit position
  localparam int DMACS_UACC_W = 2; // one user-access bit per channel
  localparam logic [1:0] DMACS_UACC_RST = 2'h0; // both channels privileged
  localparam logic DMACS_CHSEL_RST = 1'h0; // channel 0 selected
  localparam logic [31:0] DMACS_RDATA_ZERO = 32'h0000_0000; // idle read data

  // ****************************************
  // channel status
  // ****************************************
  typedef enum logic [2:0] {
    DMACS_ST_IDLE,
    DMACS_ST_QUEUED,
    DMACS_ST_RUNNING,
    DMACS_ST_COMPLETE,
    DMACS_ST_ERROR
  } dmacs_status_e;

endpackage

//--- dmacs_cp_decode.sv
/*
  combinational decode of a coprocessor register transfer into the register
  groups of the dma channel select block. assumes fields are stable while
  the request is valid.
*/
`timescale 1ns/100ps
module dmacs_cp_decode
  import dmacs_pkg::*;
(
  input wire logic [2:0] opc1,
  input wire logic [3:0] primary_register_field,
  input wire logic [3:0] secondary_register_field,
  input wire logic [2:0] opc2,
  output logic hit_uacc,
  output logic hit_chsel,
  output logic hit_cmd,
  output logic hit_bank,
  output logic hit_idstat
);

  // ****************************************
  // field match helper
  // ****************************************
  // true when opc1 and crn address the dma space and crm equals want
  function automatic logic dmacs_match(input logic [2:0] o1, input logic [3:0] rn,
                                        input logic [3:0] rm, input logic [3:0] want);
    dmacs_match = (o1 == DMACS_OPC1_DMA) && (rn == DMACS_CRN_DMA) && (rm == want);
  endfunction

  // ****************************************
  // group decode
  // ****************************************
  always_comb begin
    hit_uacc = dmacs_match(opc1, primary_register_field, secondary_register_field, DMACS_CRM_UACC) && (opc2 == DMACS_OPC2_ZERO); // R1
    hit_chsel = dmacs_match(opc1, primary_register_field, secondary_register_field, DMACS_CRM_CHSEL) && (opc2 == DMACS_OPC2_ZERO); // R6
    hit_cmd = dmacs_match(opc1, primary_register_field, secondary_register_field, DMACS_CRM_CMD); // R7
    hit_idstat = dmacs_match(opc1, primary_register_field, secondary_register_field, DMACS_CRM_IDSTAT);
    hit_bank = (opc1 == DMACS_OPC1_DMA) && (primary_register_field == DMACS_CRN_DMA) && (secondary_register_field >= DMACS_CRM_BANK_MIN);
  end

endmodule

//--- dmacs_chan_fsm.sv
/*
  status machine of one dma channel: idle, queued, running, complete, error.
  assumes the transfer datapath reports the end of a transfer with xfer_stopped
  only after all outstanding memory accesses have finished.
*/
`timescale 1ns/100ps
module dmacs_chan_fsm
  import dmacs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_halt,
  input wire logic cmd_launch,
  input wire logic cmd_clear,
  input wire logic other_busy,
  input wire logic device_region,
  input wire logic xfer_stopped,
  input wire logic xfer_err,
  input wire logic addr_err,
  input wire logic ic_en,
  input wire logic ie_en,
  output dmacs_status_e status,
  output logic in_op,
  output logic start_xfer,
  output logic halt_req,
  output logic halt_early,
  output logic err_clear,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  dmacs_status_e st_reg, st_next; // channel status
  logic start_reg, start_next; // launch pulse to datapath
  logic halt_reg, halt_next; // halt pulse to datapath
  logic early_reg, early_next; // halt may abandon accesses early
  logic clr_reg, clr_next; // error bit clear pulse
  logic irq_reg, irq_next; // completion or error interrupt

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    start_next = 1'b0;
    halt_next = 1'b0;
    early_next = early_reg;
    clr_next = 1'b0;
    irq_next = irq_reg;
    case (st_reg)
      DMACS_ST_IDLE: begin
        // launch: run now or wait behind the busy channel
        if (cmd_launch) begin
          if (other_busy) begin
            st_next = DMACS_ST_QUEUED; // R15
          end else begin
            st_next = DMACS_ST_RUNNING; // R15
            start_next = 1'b1;
          end
        end
      end
      DMACS_ST_QUEUED: begin
        if (cmd_halt) begin
          st_next = DMACS_ST_IDLE; // R13
        end else if (!other_busy) begin
          st_next = DMACS_ST_RUNNING;
          start_next = 1'b1;
        end
      end
      DMACS_ST_RUNNING: begin
        // halt only requests; status stays running until stopped
        if (cmd_halt) begin
          halt_next = 1'b1; // R9
          early_next = !device_region; // R10
        end
        if (xfer_stopped) begin
          st_next = xfer_err ? DMACS_ST_ERROR : DMACS_ST_COMPLETE; // R11 R12
          early_next = 1'b0;
          if (xfer_err ? ie_en : ic_en) begin
            irq_next = 1'b1; // R22
          end
        end
      end
      DMACS_ST_COMPLETE, DMACS_ST_ERROR: begin
        // clear keeps start addresses; only status, errors, irq change
        if (cmd_clear) begin
          st_next = DMACS_ST_IDLE; // R17 R18
          clr_next = 1'b1; // R17
          irq_next = 1'b0; // R17
        end
      end
      default: begin
        st_next = DMACS_ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= DMACS_ST_IDLE; // R23
      start_reg <= 1'b0;
      halt_reg <= 1'b0;
      early_reg <= 1'b0;
      clr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      start_reg <= start_next;
      halt_reg <= halt_next;
      early_reg <= early_next;
      clr_reg <= clr_next;
      irq_reg <= irq_next;
    end
  end

  // in operation: queued, running, or finished with an address error
  assign in_op = (st_reg == DMACS_ST_QUEUED) || (st_reg == DMACS_ST_RUNNING) ||
                 (((st_reg == DMACS_ST_COMPLETE) || (st_reg == DMACS_ST_ERROR)) && addr_err); // R16
  assign status = st_reg;
  assign start_xfer = start_reg;
  assign halt_req = halt_reg;
  assign halt_early = early_reg;
  assign err_clear = clr_reg;
  assign irq = irq_reg;

endmodule

//--- dmacs_top.sv
/*
  dma channel selection and command control: user access bits, channel
  selector, halt/launch/clear command registers and two channel status
  machines. assumes the core presents one coprocessor transfer per cycle at
  most, synchronous to ref_clk, and that the transfer datapath, the banked
  per-channel registers and the interrupt combiner sit outside.
*/
// Notes on behaviour
// R1: user access register at c11, c1, op 0
// R2: privileged access works, user access traps
// R3: selector bit 0 picks channel, resets 0
// R4: banked registers follow the selected channel
// R5: user selector access needs any user bit
// R6: selector register at c11, c2, op 0
// R7: three write-only commands: halt, launch, clear
// R8: user commands need selected channel user bit
// R9: halt stops running channel, status stays running
// R10: no early abandon for device memory
// R11: complete or error after outstanding accesses
// R12: start addresses allow resuming after halt
// R13: halt of queued channel returns to idle
// R14: halt ignored outside running or queued
// R15: launch runs, or queues behind busy channel
// R16: in operation: queued, running, finished with error
// R17: clear finishes to idle, clears errors, irq
// R18: clear keeps start address registers
// R19: clear ignored while running or queued
// R20: user bits reset 0, mark transfer privilege
// R21: command reads trap; user writes need bit
// R22: completion interrupt when enabled, also on halt
// R23: channels idle after reset
`timescale 1ns/100ps
module dmacs_top
  import dmacs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // coprocessor register transfer from the core
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic cp_user,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  output logic [31:0] cp_rdata,
  output logic cp_done,
  output logic cp_undef,
  // forwarding to the banked per-channel registers
  output logic bank_req,
  output logic bank_chan,
  // transfer datapath, one bit per channel
  input wire logic [1:0] device_region,
  input wire logic [1:0] xfer_stopped,
  input wire logic [1:0] xfer_err,
  input wire logic [1:0] addr_err,
  input wire logic [1:0] ic_en,
  input wire logic [1:0] ie_en,
  output logic [1:0] start_xfer,
  output logic [1:0] halt_req,
  output logic [1:0] halt_early,
  output logic [1:0] err_clear,
  output logic [1:0] xfer_priv,
  output logic [1:0] chan_irq,
  output dmacs_status_e chan0_status,
  output dmacs_status_e chan1_status,
  output logic channel_select_bit
);

  // ****************************************
  // declarations
  // ****************************************
  logic [1:0] uacc_reg, uacc_next; // user access bits, one per channel
  logic chsel_reg, chsel_next; // selected channel
  logic [31:0] rdata_reg, rdata_next; // registered read data
  logic done_reg, done_next; // transfer accepted pulse
  logic undef_reg, undef_next; // undefined instruction pulse
  logic bank_req_reg, bank_req_next; // forward pulse to banked file
  logic bank_chan_reg, bank_chan_next; // channel of the forwarded access
  logic hit_uacc; // user access register addressed
  logic hit_chsel; // selector addressed
  logic hit_cmd; // command registers addressed
  logic hit_bank; // banked register addressed
  logic hit_idstat; // id and status registers, not ours
  logic sel_user_ok; // user bit of the selected channel
  logic any_user_ok; // any user bit set
  logic [1:0] cmd_halt; // halt command per channel
  logic [1:0] cmd_launch; // launch command per channel
  logic [1:0] cmd_clear; // clear command per channel
  logic [1:0] in_op; // channel in operation
  dmacs_status_e status_w [DMACS_NUM_CH]; // status per channel

  // ****************************************
  // address decode
  // ****************************************
  dmacs_cp_decode u_decode (
    .opc1(cp_opc1),
    .primary_register_field(cp_crn),
    .secondary_register_field(cp_crm),
    .opc2(cp_opc2),
    .hit_uacc(hit_uacc),
    .hit_chsel(hit_chsel),
    .hit_cmd(hit_cmd),
    .hit_bank(hit_bank),
    .hit_idstat(hit_idstat)
  );

  // permission terms used by several groups
  assign sel_user_ok = uacc_reg[chsel_reg];
  assign any_user_ok = |uacc_reg;

  // ****************************************
  // request handling
  // ****************************************
  // one request per cycle, answered one cycle later
  always_comb begin
    uacc_next = uacc_reg;
    chsel_next = chsel_reg;
    rdata_next = DMACS_RDATA_ZERO;
    done_next = 1'b0;
    undef_next = 1'b0;
    bank_req_next = 1'b0;
    bank_chan_next = bank_chan_reg;
    cmd_halt = 2'h0;
    cmd_launch = 2'h0;
    cmd_clear = 2'h0;
    if (cp_valid) begin
      if (hit_uacc) begin
        // user access register: privileged only
        if (cp_user) begin
          undef_next = 1'b1; // R2
        end else begin
          done_next = 1'b1; // R2
          if (cp_write) begin
            uacc_next = cp_wdata[DMACS_UACC_W-1:0]; // R1
          end else begin
            rdata_next = {30'h0000_0000, uacc_reg}; // R1
          end
        end
      end else if (hit_chsel) begin
        // selector: user mode needs at least one user bit
        if (cp_user && !any_user_ok) begin
          undef_next = 1'b1; // R5
        end else begin
          done_next = 1'b1; // R5
          if (cp_write) begin
            chsel_next = cp_wdata[DMACS_CHSEL_BIT]; // R3 R6
          end else begin
            rdata_next = {31'h0000_0000, chsel_reg}; // R3 R6
          end
        end
      end else if (hit_cmd) begin
        // commands: write only, user needs selected channel bit
        if (!cp_write) begin
          undef_next = 1'b1; // R21
        end else if (cp_user && !sel_user_ok) begin
          undef_next = 1'b1; // R8 R21
        end else begin
          case (cp_opc2)
            DMACS_OPC2_HALT: begin
              done_next = 1'b1;
              cmd_halt[chsel_reg] = 1'b1; // R7
            end
            DMACS_OPC2_LAUNCH: begin
              done_next = 1'b1;
              cmd_launch[chsel_reg] = 1'b1; // R7
            end
            DMACS_OPC2_CLEAR: begin
              done_next = 1'b1;
              cmd_clear[chsel_reg] = 1'b1; // R7
            end
            default: begin
              // reserved second opcodes
              undef_next = 1'b1;
            end
          endcase
        end
      end else if (hit_bank) begin
        // banked registers: steer to selected channel
        if (cp_user && !sel_user_ok) begin
          undef_next = 1'b1; // R20
        end else begin
          bank_req_next = 1'b1; // R4
          bank_chan_next = chsel_reg; // R4
        end
      end else if (!hit_idstat) begin
        // anything else in this space is undefined
        undef_next = 1'b1;
      end
    end
  end

  // ****************************************
  // request registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uacc_reg <= DMACS_UACC_RST; // R20
      chsel_reg <= DMACS_CHSEL_RST; // R3
      rdata_reg <= DMACS_RDATA_ZERO;
      done_reg <= 1'b0;
      undef_reg <= 1'b0;
      bank_req_reg <= 1'b0;
      bank_chan_reg <= DMACS_CHSEL_RST;
    end else begin
      uacc_reg <= uacc_next;
      chsel_reg <= chsel_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      undef_reg <= undef_next;
      bank_req_reg <= bank_req_next;
      bank_chan_reg <= bank_chan_next;
    end
  end

  // ****************************************
  // channel status machines
  // ****************************************
  // each channel sees the other one's operation state
  for (genvar ch = 0; ch < DMACS_NUM_CH; ch++) begin : g_chan
    dmacs_chan_fsm u_fsm (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .cmd_halt(cmd_halt[ch]), // R14
      .cmd_launch(cmd_launch[ch]),
      .cmd_clear(cmd_clear[ch]), // R19
      .other_busy(in_op[1-ch]), // R15 R16
      .device_region(device_region[ch]),
      .xfer_stopped(xfer_stopped[ch]),
      .xfer_err(xfer_err[ch]),
      .addr_err(addr_err[ch]),
      .ic_en(ic_en[ch]),
      .ie_en(ie_en[ch]),
      .status(status_w[ch]),
      .in_op(in_op[ch]),
      .start_xfer(start_xfer[ch]),
      .halt_req(halt_req[ch]),
      .halt_early(halt_early[ch]),
      .err_clear(err_clear[ch]),
      .irq(chan_irq[ch])
    );
  end

  // ****************************************
  // outputs
  // ****************************************
  // transfers are privileged unless the channel's user bit is set
  assign xfer_priv = ~uacc_reg; // R20
  assign cp_rdata = rdata_reg;
  assign cp_done = done_reg;
  assign cp_undef = undef_reg;
  assign bank_req = bank_req_reg;
  assign bank_chan = bank_chan_reg;
  assign chan0_status = status_w[0];
  assign chan1_status = status_w[1];
  assign channel_select_bit = chsel_reg;

endmodule

//--- dmacs_checker.sv
/*
  concurrent checks on the ports of the dma channel select block.
  assumes it is bound to dmacs_top and sees its ports only.
*/
`timescale 1ns/100ps
module dmacs_checker
  import dmacs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic cp_user,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_done,
  input wire logic cp_undef,
  input wire logic bank_req,
  input wire logic bank_chan,
  input wire logic [1:0] device_region,
  input wire logic [1:0] xfer_stopped,
  input wire logic [1:0] start_xfer,
  input wire logic [1:0] halt_req,
  input wire logic [1:0] halt_early,
  input dmacs_status_e chan0_status,
  input dmacs_status_e chan1_status,
  input wire logic channel_select_bit
);
  // ****************************************
  // request decode helpers
  // ****************************************
  logic in_c11; // first opcode and primary register match
  logic cmd0; // privileged command write to channel 0
  assign in_c11 = cp_valid && cp_opc1 == DMACS_OPC1_DMA && cp_crn == DMACS_CRN_DMA;
  assign cmd0 = in_c11 && cp_write && !cp_user && cp_crm == DMACS_CRM_CMD && !channel_select_bit;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // assertions
  // ****************************************
  a_uacc_user_trap: assert property (in_c11 && cp_user && cp_crm == DMACS_CRM_UACC
    |=> cp_undef && !cp_done) else $error("user access to user bits not trapped");
  a_uacc_priv_ok: assert property (in_c11 && !cp_user && cp_crm == DMACS_CRM_UACC
    && cp_opc2 == DMACS_OPC2_ZERO |=> cp_done && !cp_undef) else $error("user bits access failed");
  a_cmd_read_trap: assert property (in_c11 && !cp_write && cp_crm == DMACS_CRM_CMD
    |=> cp_undef) else $error("command read not trapped");
  a_select_write: assert property (in_c11 && cp_write && !cp_user && cp_crm == DMACS_CRM_CHSEL
    && cp_opc2 == DMACS_OPC2_ZERO |=> channel_select_bit == $past(cp_wdata[0]))
    else $error("selector write lost");
  a_bank_follows: assert property (bank_req |-> bank_chan == channel_select_bit)
    else $error("banked access on wrong channel");
  a_launch_runs: assert property (cmd0 && cp_opc2 == DMACS_OPC2_LAUNCH
    && chan0_status == DMACS_ST_IDLE && chan1_status == DMACS_ST_IDLE
    |=> chan0_status == DMACS_ST_RUNNING && start_xfer[0]) else $error("launch did not run");
  a_halt_queued: assert property (cmd0 && cp_opc2 == DMACS_OPC2_HALT
    && chan0_status == DMACS_ST_QUEUED |=> chan0_status == DMACS_ST_IDLE)
    else $error("queued halt not idle");
  a_halt_running: assert property (cmd0 && cp_opc2 == DMACS_OPC2_HALT
    && chan0_status == DMACS_ST_RUNNING && !xfer_stopped[0] |=> chan0_status == DMACS_ST_RUNNING
    && halt_req[0] && halt_early[0] == !$past(device_region[0]))
    else $error("halt of running channel wrong");
  a_clear_busy: assert property (cmd0 && cp_opc2 == DMACS_OPC2_CLEAR
    && chan0_status == DMACS_ST_RUNNING && !xfer_stopped[0] |=> chan0_status == DMACS_ST_RUNNING)
    else $error("clear changed running channel");
  a_end_after_stop: assert property (chan0_status == DMACS_ST_RUNNING && !xfer_stopped[0]
    |=> chan0_status == DMACS_ST_RUNNING || chan0_status == DMACS_ST_IDLE)
    else $error("channel ended without stop");
  a_idle_reset: assert property ($rose(rst_n) |-> chan0_status == DMACS_ST_IDLE
    && chan1_status == DMACS_ST_IDLE) else $error("status not idle after reset");

  // ****************************************
  // covers
  // ****************************************
  c_launch: cover property (start_xfer[0]);
  c_queue: cover property (chan1_status == DMACS_ST_QUEUED);
  c_trap: cover property (cp_undef);
endmodule

bind dmacs_top dmacs_checker dmacs_checker_i (.*);

//--- dmacs_core_model.sv
/*
  model of the core issuing coprocessor register transfers, one at a time.
  assumes the block registers its answer on the taken edge itself.
*/
`timescale 1ns/100ps
module dmacs_core_model
  import dmacs_pkg::*;
(
  input wire logic ref_clk,
  output logic cp_valid,
  output logic cp_write,
  output logic cp_user,
  output logic [2:0] cp_opc1,
  output logic [3:0] cp_crn,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_opc2,
  output logic [31:0] cp_wdata,
  input wire logic [31:0] cp_rdata,
  input wire logic cp_done,
  input wire logic cp_undef
);
  // idle values before any transfer
  initial begin
    cp_valid = 1'h0;
    cp_write = 1'h0;
    cp_user = 1'h0;
    cp_opc1 = 3'h7;
    cp_crn = 4'h0;
    cp_crm = 4'hF;
    cp_opc2 = 3'h7;
    cp_wdata = 32'hFFFF_FFFF;
  end

  // one transfer: hold fields to the taken edge, then scramble them
  task automatic access(input logic w, input logic u, input logic [3:0] secondary_register_field,
                        input logic [2:0] opc2, input logic [31:0] wd,
                        output logic [31:0] rd, output logic dn, output logic ud);
    @(posedge ref_clk);
    cp_valid <= 1'h1;
    cp_write <= w;
    cp_user <= u;
    cp_opc1 <= DMACS_OPC1_DMA;
    cp_crn <= DMACS_CRN_DMA;
    cp_crm <= secondary_register_field;
    cp_opc2 <= opc2;
    cp_wdata <= wd;
    @(posedge ref_clk);
    cp_valid <= 1'h0;
    cp_opc1 <= ~DMACS_OPC1_DMA;
    cp_crn <= ~DMACS_CRN_DMA;
    cp_crm <= ~secondary_register_field;
    cp_opc2 <= ~opc2;
    cp_wdata <= ~wd;
    #1;
    rd = cp_rdata;
    dn = cp_done;
    ud = cp_undef;
  endtask
endmodule

//--- test_dmacs_top.sv
/*
  self-checking bench for the dma channel select block: access rules,
  selector, and the halt/launch/clear status machine.
  assumes the core model and the bound checker.
*/
`timescale 1ns/100ps
module test_dmacs_top
  import dmacs_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cp_valid, cp_write, cp_user, cp_done, cp_undef, bank_req, bank_chan;
  logic channel_select_bit;
  logic [2:0] cp_opc1, cp_opc2;
  logic [3:0] cp_crn, cp_crm;
  logic [31:0] cp_wdata, cp_rdata;
  logic [1:0] device_region = 2'h0, xfer_stopped = 2'h0, xfer_err = 2'h0;
  logic [1:0] addr_err = 2'h0, ic_en = 2'h3, ie_en = 2'h3;
  logic [1:0] start_xfer, halt_req, halt_early, err_clear, xfer_priv, chan_irq;
  dmacs_status_e chan0_status, chan1_status;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  always #50 ref_clk = ~ref_clk;

  dmacs_core_model dmacs_core_model_i (.*);
  dmacs_top dmacs_top_i (.*);

  // one comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // transfer with expected outcome: ok=1 accepted, 0 trapped
  task automatic acc(input logic w, input logic u, input logic [3:0] secondary_register_field, input logic [2:0] op2,
                     input logic [31:0] wd, input logic ok, input logic [31:0] erd);
    logic [31:0] rd;
    logic dn, ud;
    dmacs_core_model_i.access(w, u, secondary_register_field, op2, wd, rd, dn, ud);
    chk("done", {31'h0, ok}, {31'h0, dn});
    chk("undef", {31'h0, !ok}, {31'h0, ud});
    chk("rdata", (ok && !w) ? erd : 32'h0000_0000, rd);
  endtask

  // privileged command write and selector write, both accepted
  task automatic cmd(input logic [2:0] op);
    acc(1'h1, 1'h0, DMACS_CRM_CMD, op, 32'h0, 1'h1, 32'h0);
  endtask
  task automatic sel(input logic [31:0] v);
    acc(1'h1, 1'h0, DMACS_CRM_CHSEL, 3'h0, v, 1'h1, 32'h0);
  endtask

  // status of both channels
  task automatic st(input dmacs_status_e e0, input dmacs_status_e e1);
    chk("chan0_status", 32'(e0), 32'(chan0_status));
    chk("chan1_status", 32'(e1), 32'(chan1_status));
  endtask

  // one-cycle stop pulse from the datapath
  task automatic stop(input logic [1:0] m);
    @(posedge ref_clk);
    xfer_stopped <= m;
    @(posedge ref_clk);
    xfer_stopped <= 2'h0;
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] brd;
    logic bdn, bud;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1;
    // ****************************************
    // reset values
    // ****************************************
    st(DMACS_ST_IDLE, DMACS_ST_IDLE);
    chk("select", 32'h0, {31'h0, channel_select_bit});
    chk("xfer_priv", 32'h3, {30'h0, xfer_priv});
    acc(1'h0, 1'h0, DMACS_CRM_UACC, 3'h0, 32'h0, 1'h1, 32'h0);
    acc(1'h0, 1'h0, DMACS_CRM_CHSEL, 3'h0, 32'h0, 1'h1, 32'h0);
    $display("test reset done");
    // ****************************************
    // access permissions
    // ****************************************
    acc(1'h0, 1'h1, DMACS_CRM_UACC, 3'h0, 32'h0, 1'h0, 32'h0);
    acc(1'h0, 1'h1, DMACS_CRM_CHSEL, 3'h0, 32'h0, 1'h0, 32'h0);
    acc(1'h1, 1'h0, DMACS_CRM_UACC, 3'h0, 32'h2, 1'h1, 32'h0);
    acc(1'h0, 1'h0, DMACS_CRM_UACC, 3'h0, 32'h0, 1'h1, 32'h2);
    chk("xfer_priv", 32'h1, {30'h0, xfer_priv});
    acc(1'h1, 1'h1, DMACS_CRM_UACC, 3'h0, 32'h0, 1'h0, 32'h0);
    acc(1'h1, 1'h1, DMACS_CRM_CHSEL, 3'h0, 32'h1, 1'h1, 32'h0);
    acc(1'h0, 1'h1, DMACS_CRM_CHSEL, 3'h0, 32'h0, 1'h1, 32'h1);
    acc(1'h1, 1'h1, DMACS_CRM_CMD, DMACS_OPC2_HALT, 32'h0, 1'h1, 32'h0);
    st(DMACS_ST_IDLE, DMACS_ST_IDLE);
    sel(32'h0);
    acc(1'h1, 1'h1, DMACS_CRM_CMD, DMACS_OPC2_LAUNCH, 32'h0, 1'h0, 32'h0);
    st(DMACS_ST_IDLE, DMACS_ST_IDLE);
    for (int k = 0; k < 3; k++) begin
      acc(1'h0, 1'h0, DMACS_CRM_CMD, 3'(k), 32'h0, 1'h0, 32'h0);
    end
    acc(1'h1, 1'h0, DMACS_CRM_CMD, 3'h3, 32'h0, 1'h0, 32'h0);
    acc(1'h0, 1'h0, DMACS_CRM_UACC, 3'h1, 32'h0, 1'h0, 32'h0);
    dmacs_core_model_i.access(1'h0, 1'h0, DMACS_CRM_BANK_MIN, 3'h0, 32'h0, brd, bdn, bud);
    chk("bank_req", 32'h1, {31'h0, bank_req});
    chk("bank undef", 32'h0, {31'h0, bud});
    acc(1'h1, 1'h0, DMACS_CRM_UACC, 3'h0, 32'h0, 1'h1, 32'h0);
    $display("test access done");
    // ****************************************
    // commands and status
    // ****************************************
    device_region <= 2'h1;
    cmd(DMACS_OPC2_LAUNCH);
    chk("start_xfer", 32'h1, {30'h0, start_xfer});
    st(DMACS_ST_RUNNING, DMACS_ST_IDLE);
    sel(32'h1);
    cmd(DMACS_OPC2_LAUNCH);
    st(DMACS_ST_RUNNING, DMACS_ST_QUEUED);
    cmd(DMACS_OPC2_HALT);
    st(DMACS_ST_RUNNING, DMACS_ST_IDLE);
    cmd(DMACS_OPC2_LAUNCH);
    cmd(DMACS_OPC2_CLEAR);
    st(DMACS_ST_RUNNING, DMACS_ST_QUEUED);
    sel(32'h0);
    cmd(DMACS_OPC2_HALT);
    chk("halt_req", 32'h1, {30'h0, halt_req});
    chk("halt_early", 32'h0, {30'h0, halt_early});
    repeat (3) @(posedge ref_clk);
    #1;
    st(DMACS_ST_RUNNING, DMACS_ST_QUEUED);
    stop(2'h1);
    st(DMACS_ST_COMPLETE, DMACS_ST_QUEUED);
    chk("chan_irq", 32'h1, {30'h0, chan_irq});
    repeat (2) @(posedge ref_clk);
    #1;
    chk("chan1_status", 32'(DMACS_ST_RUNNING), 32'(chan1_status));
    cmd(DMACS_OPC2_HALT);
    st(DMACS_ST_COMPLETE, DMACS_ST_RUNNING);
    cmd(DMACS_OPC2_CLEAR);
    chk("err_clear", 32'h1, {30'h0, err_clear});
    chk("chan_irq", 32'h0, {30'h0, chan_irq});
    st(DMACS_ST_IDLE, DMACS_ST_RUNNING);
    sel(32'h1);
    cmd(DMACS_OPC2_HALT);
    chk("halt_early", 32'h2, {30'h0, halt_early});
    xfer_err <= 2'h2;
    addr_err <= 2'h2;
    stop(2'h2);
    st(DMACS_ST_IDLE, DMACS_ST_ERROR);
    chk("chan_irq", 32'h2, {30'h0, chan_irq});
    sel(32'h0);
    cmd(DMACS_OPC2_LAUNCH);
    st(DMACS_ST_QUEUED, DMACS_ST_ERROR);
    sel(32'h1);
    cmd(DMACS_OPC2_CLEAR);
    chk("chan1_status", 32'(DMACS_ST_IDLE), 32'(chan1_status));
    repeat (2) @(posedge ref_clk);
    #1;
    chk("chan0_status", 32'(DMACS_ST_RUNNING), 32'(chan0_status));
    $display("test commands done");
    tally_and_finish();
  end
endmodule
